/* logic/aalu_core.v */
// accumulator datapath with operand fetch and status word
`timescale 1ns/1ns
`include "aalu_defines.vh"
module aalu_core (
   input wire clock, // core clock, 20 MHz
   input wire rst_b, // asynchronous reset, active low
   input wire clk_en, // freezes all state while low
   input wire op_valid, // one-cycle pulse starts an operation
   input wire [2:0] op_code, // operation select
   input wire [1:0] src_sel, // operand source select
   input wire [7:0] direct_addr, // direct address field
   input wire [7:0] imm_data, // immediate byte
   input wire [7:0] mem_rdata, // data memory read data, sampled in the same cycle as the read strobe
   input wire ptr_wr, // load a pointer or status from the core
   input wire [7:0] ptr_waddr, // address of that load, in register memory or the status word address
   input wire [7:0] ptr_wdata, // value of that load
   output wire op_ready, // high when idle and able to take an operation
   output reg mem_rd, // data memory read strobe
   output reg [7:0] mem_addr, // data memory address
   output reg [7:0] acc_out, // accumulator
   output reg [7:0] program_status_word, // status word
   output reg skip_next, // pulse: skip following instruction
   output reg done, // pulse: operation finished
   output reg [7:0] ptr_b_out, // first pointer
   output reg [7:0] ptr_x_out, // second pointer
   output reg [7:0] sp_out // stack pointer
);
   localparam ST_IDLE = 2'h0; // waiting for an operation
   localparam ST_FETCH = 2'h1; // memory read in flight
   localparam ST_EXEC = 2'h2; // operand present, compute
   reg [1:0] state_reg; // control state
   reg [1:0] state_next; // next control state
   reg [2:0] op_reg; // latched operation
   reg [7:0] opnd_reg; // latched operand
   reg [7:0] add_b; // adder operand after inversion
   reg add_cin; // adder carry in
   wire [7:0] sum; // adder result
   wire carry_out; // adder carry
   wire half_carry_out; // adder nibble carry
   wire carry_flag; // current carry
   wire [7:0] and_val; // logical and result
   // register memory window test, used only for the pointer loads
   function is_regmem;
      input [7:0] addr;
      begin
         is_regmem = ((addr & `AALU_REGMEM_MASK) == `AALU_REGMEM_BASE);
      end
   endfunction
   assign carry_flag = program_status_word[`AALU_STAT_CARRY_BIT];
   assign and_val = acc_out & opnd_reg;
   assign op_ready = (state_reg == ST_IDLE);
   // adder input shaping: subtract adds the inverse plus carry
   always @*
   begin
      add_b = opnd_reg;
      add_cin = 1'b0;
      case (op_reg)
         `AALU_OP_ADC:
         begin
            add_cin = carry_flag;
         end
         `AALU_OP_SUB_CARRY:
         begin
            add_b = ~opnd_reg;
            add_cin = carry_flag;
         end
         default:
         begin
            add_b = opnd_reg;
         end
      endcase
   end
   aalu_addsub u_addsub (
      .a_in(acc_out),
      .b_in(add_b),
      .cin(add_cin),
      .sum_out(sum),
      .cout(carry_out),
      .hcout(half_carry_out)
   );
   // next state; immediate skips the memory wait
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (op_valid && op_code != `AALU_OP_NONE)
            begin
               // and-skip always uses the immediate byte
               if (src_sel == `AALU_SRC_IMM || op_code == `AALU_OP_AND_SKIP)
                  state_next = ST_EXEC;
               else
                  state_next = ST_FETCH;
            end
         end
         ST_FETCH:
         begin
            state_next = ST_EXEC;
         end
         ST_EXEC:
         begin
            state_next = ST_IDLE;
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end
   // state, operand capture, accumulator and flag update
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= ST_IDLE;
         op_reg <= `AALU_OP_NONE;
         opnd_reg <= `AALU_DATA_RST;
         mem_rd <= 1'b0;
         mem_addr <= `AALU_DATA_RST;
         acc_out <= `AALU_ACC_RST;
         program_status_word <= `AALU_STAT_RST;
         skip_next <= 1'b0;
         done <= 1'b0;
         ptr_b_out <= `AALU_PTR_RST;
         ptr_x_out <= `AALU_PTR_RST;
         sp_out <= `AALU_PTR_RST;
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
         mem_rd <= 1'b0;
         skip_next <= 1'b0;
         done <= 1'b0;
         // pointer and stack loads into register memory
         if (ptr_wr && is_regmem(ptr_waddr))
         begin
            case (ptr_waddr)
               `AALU_ADDR_B: ptr_b_out <= ptr_wdata;
               `AALU_ADDR_X: ptr_x_out <= ptr_wdata;
               `AALU_ADDR_SP: sp_out <= ptr_wdata;
               default: ptr_b_out <= ptr_b_out;
            endcase
         end
         case (state_reg)
            ST_IDLE:
            begin
               if (op_valid && op_code != `AALU_OP_NONE)
               begin
                  op_reg <= op_code;
                  opnd_reg <= imm_data;
                  mem_rd <= (state_next == ST_FETCH);
                  case (src_sel)
                     `AALU_SRC_PTR_B: mem_addr <= ptr_b_out;
                     `AALU_SRC_PTR_X: mem_addr <= ptr_x_out;
                     default: mem_addr <= direct_addr;
                  endcase
               end
            end
            ST_FETCH:
            begin
               opnd_reg <= mem_rdata;
            end
            ST_EXEC:
            begin
               done <= 1'b1;
               case (op_reg)
                  `AALU_OP_ADD:
                  begin
                     acc_out <= sum;
                  end
                  `AALU_OP_ADC, `AALU_OP_SUB_CARRY:
                  begin
                     acc_out <= sum;
                     program_status_word[`AALU_STAT_CARRY_BIT] <= carry_out;
                     program_status_word[`AALU_STAT_HALF_CARRY_BIT] <= half_carry_out;
                  end
                  `AALU_OP_AND: acc_out <= and_val;
                  `AALU_OP_OR: acc_out <= acc_out | opnd_reg;
                  `AALU_OP_XOR: acc_out <= acc_out ^ opnd_reg;
                  `AALU_OP_AND_SKIP:
                  begin
                     // accumulator untouched; only the skip decision
                     skip_next <= (and_val == 8'h00);
                  end
                  default: acc_out <= acc_out;
               endcase
            end
            default:
            begin
               mem_rd <= 1'b0;
            end
         endcase
         // status word load from the core, last so it wins
         if (ptr_wr && ptr_waddr == `AALU_ADDR_STAT)
            program_status_word <= ptr_wdata;
      end
   end
endmodule

/* logic/aalu_defines.vh */
// constants for the accumulator arithmetic and logic unit
// Overview of operation
// - add with carry: a plus operand plus carry
// - subtract with carry: a plus inverted operand plus carry (a minus operand minus one plus carry)
// - and immediate; skip next when result zero
// - operand from direct, first or second pointer, or immediate
// - addresses f0 to ff are register memory
// - carry, half carry, irq enable in status word
// - indirect operand address from a pointer register
`ifndef AALU_DEFINES_VH
`define AALU_DEFINES_VH
// operation codes
`define AALU_OP_ADD 3'h0
`define AALU_OP_ADC 3'h1
`define AALU_OP_SUB_CARRY 3'h2
`define AALU_OP_AND 3'h3
`define AALU_OP_AND_SKIP 3'h4
`define AALU_OP_OR 3'h5
`define AALU_OP_XOR 3'h6
`define AALU_OP_NONE 3'h7
// operand source selects
`define AALU_SRC_DIRECT 2'h0
`define AALU_SRC_PTR_B 2'h1
`define AALU_SRC_IMM 2'h2
`define AALU_SRC_PTR_X 2'h3
// status word bit positions
`define AALU_STAT_IRQ_EN_BIT 0
`define AALU_STAT_CARRY_BIT 7
`define AALU_STAT_HALF_CARRY_BIT 6
// register memory window base and the mask that isolates it
`define AALU_REGMEM_BASE 8'hF0
`define AALU_REGMEM_MASK 8'hF0
// status word address, just below the register window
`define AALU_ADDR_STAT 8'hEF
// pointer register addresses inside register memory
`define AALU_ADDR_X 8'hFC
`define AALU_ADDR_SP 8'hFD
`define AALU_ADDR_B 8'hFE
// reset values
`define AALU_ACC_RST 8'h00
`define AALU_STAT_RST 8'h00
`define AALU_PTR_RST 8'h00
`define AALU_DATA_RST 8'h00
`endif

/* logic/aalu_addsub.v */
// eight bit adder with nibble carry, shared by add and subtract
`timescale 1ns/1ns
module aalu_addsub (
   input wire [7:0] a_in, // accumulator value
   input wire [7:0] b_in, // operand, already inverted for subtract
   input wire cin, // carry in
   output wire [7:0] sum_out, // eight bit result
   output wire cout, // carry out of bit 7
   output wire hcout // carry out of bit 3
);
   wire [4:0] low_sum; // low nibble with its carry
   wire [4:0] high_sum; // high nibble with its carry
   // subtract as add of the inverse: carry set means no borrow
   assign low_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin};
   assign high_sum = {1'b0, a_in[7:4]} + {1'b0, b_in[7:4]} + {4'h0, low_sum[4]};
   assign sum_out = {high_sum[3:0], low_sum[3:0]};
   assign cout = high_sum[4];
   assign hcout = low_sum[4];
endmodule

/* tb/aalu_core_props.sv */
// timing and addressing checks for the accumulator unit
`timescale 1ns/1ns
module aalu_core_props (
   input wire logic clock, // core clock
   input wire logic rst_b, // async reset, active low
   input wire logic clk_en, // stall control
   input wire logic op_valid, // operation request
   input wire logic [2:0] op_code, // operation select
   input wire logic [1:0] src_sel, // operand source
   input wire logic [7:0] direct_addr, // direct address
   input wire logic op_ready, // idle flag
   input wire logic mem_rd, // read strobe
   input wire logic [7:0] mem_addr, // read address
   input wire logic done, // completion pulse
   input wire logic skip_next, // skip pulse
   input wire logic [7:0] ptr_b_out, // first pointer
   input wire logic [7:0] ptr_x_out // second pointer
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // an accepted request; code 7 is a no-op
   wire take = clk_en && op_valid && op_ready && op_code != 3'h7;
   // and-skip always uses the immediate byte
   wire memop = src_sel != 2'h2 && op_code != 3'h4;
   sequence s_take_mem; take && memop; endsequence
   sequence s_take_imm; take && !memop; endsequence
   property p_rd; s_take_mem |=> mem_rd; endproperty
   a_rd: assert property (p_rd) else $error("no read strobe");
   property p_no_rd; s_take_imm |=> !mem_rd; endproperty
   a_no_rd: assert property (p_no_rd) else $error("read on immediate");
   property p_mem_done; s_take_mem |=> !done ##1 !done ##1 done; endproperty
   a_mem_done: assert property (p_mem_done) else $error("memory op timing");
   property p_imm_done; s_take_imm |=> !done ##1 done; endproperty
   a_imm_done: assert property (p_imm_done) else $error("immediate op timing");
   property p_adr_d; s_take_mem and src_sel == 2'h0 |=> mem_addr == $past(direct_addr); endproperty
   a_adr_d: assert property (p_adr_d) else $error("direct address");
   property p_adr_b; s_take_mem and src_sel == 2'h1 |=> mem_addr == $past(ptr_b_out); endproperty
   a_adr_b: assert property (p_adr_b) else $error("first pointer address");
   property p_adr_x; s_take_mem and src_sel == 2'h3 |=> mem_addr == $past(ptr_x_out); endproperty
   a_adr_x: assert property (p_adr_x) else $error("second pointer address");
   property p_skip; skip_next |-> done; endproperty
   a_skip: assert property (p_skip) else $error("skip outside completion");
   property p_busy; s_take_mem |=> !op_ready [*2] ##1 op_ready; endproperty
   a_busy: assert property (p_busy) else $error("ready while busy");
   property p_busy_imm; s_take_imm |=> !op_ready ##1 op_ready; endproperty
   a_busy_imm: assert property (p_busy_imm) else $error("ready while busy on immediate");
   property p_rdy; done |-> op_ready && !mem_rd; endproperty
   a_rdy: assert property (p_rdy) else $error("not ready at completion");
endmodule
bind aalu_core aalu_core_props i_props (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .op_valid(op_valid),
   .op_code(op_code), .src_sel(src_sel), .direct_addr(direct_addr), .op_ready(op_ready), .mem_rd(mem_rd),
   .mem_addr(mem_addr), .done(done), .skip_next(skip_next), .ptr_b_out(ptr_b_out), .ptr_x_out(ptr_x_out));

/* tb/tb_top.sv */
// random self-checking bench for the accumulator unit
`timescale 1ns/1ns
module tb_top;
   reg clock = 0, rst_b = 0, clk_en = 0, op_valid = 0, ptr_wr = 0; // control inputs
   reg [2:0] op_code = 0; // operation select
   reg [1:0] src_sel = 0; // operand source
   reg [7:0] direct_addr = 0, imm_data = 0, ptr_waddr = 0, ptr_wdata = 0; // data inputs
   reg [7:0] mem_rdata; // memory answer
   reg [7:0] mv = 0, p = 0, m = 0, mm = 0; // memory byte, status load, operands
   reg [7:0] bv = 0, xv = 0, spv = 0, ea = 0; // expected pointers and operand address
   wire op_ready, mem_rd, done, skip_next; // design flags
   wire [7:0] mem_addr, acc_out, stat_word, ptr_b, ptr_x, sp; // design values
   int errors = 0, n_tests = 0, seed = 75331, i, k, op, src, a = 0, c, hc, r, sk; // model state
   aalu_core i_aalu_core (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .op_valid(op_valid),
      .op_code(op_code), .src_sel(src_sel), .direct_addr(direct_addr), .imm_data(imm_data),
      .mem_rdata(mem_rdata), .ptr_wr(ptr_wr), .ptr_waddr(ptr_waddr), .ptr_wdata(ptr_wdata),
      .op_ready(op_ready), .mem_rd(mem_rd), .mem_addr(mem_addr), .acc_out(acc_out),
      .program_status_word(stat_word), .skip_next(skip_next), .done(done), .ptr_b_out(ptr_b), .ptr_x_out(ptr_x),
      .sp_out(sp));
   function logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task chk(input [7:0] g, input [7:0] e);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task test_done;
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // register-memory or status word load, one per cycle
   task ld(input [7:0] ad, input [7:0] d);
      @(posedge clock);
      ptr_wr <= 1;
      ptr_waddr <= ad;
      ptr_wdata <= d;
   endtask
   initial forever #25 clock = ~clock;
   // memory answers while the strobe stands, data tied to the address; garbage otherwise
   always @* mem_rdata = mem_rd ? (mv ^ mem_addr) : ~mv;
   initial
   begin
      repeat (2) @(posedge clock);
      rst_b <= 1;
      clk_en <= 1;
      #1 chk(acc_out, 8'h00);
      chk(stat_word, 8'h00);
      for (i = 0; i < 200; i++)
      begin
         op = rnd() % 7;
         src = rnd() % 4;
         p = rnd();
         mv = rnd();
         bv = rnd();
         xv = rnd();
         ld(8'hFE, bv);
         ld(8'hFC, xv);
         // a no-op request while idle must start nothing
         op_valid <= 1;
         op_code <= 3'h7;
         m = rnd();
         ld(8'hFD, m);
         op_valid <= 0;
         // every third pass stalls the stack pointer load: it must be lost
         clk_en <= (i % 3 != 0);
         if (i % 3 != 0)
            spv = m;
         ld(8'hEF, p);
         clk_en <= 1;
         @(posedge clock);
         ptr_wr <= 0;
         op_valid <= 1;
         op_code <= op[2:0];
         src_sel <= src[1:0];
         direct_addr <= rnd();
         imm_data <= rnd();
         @(posedge clock);
         // odd passes hold the request while busy: it must be ignored
         if (i % 2)
         begin
            op_code <= 3'h0;
            @(posedge clock);
         end
         op_valid <= 0;
         ea = (src == 0) ? direct_addr : (src == 1) ? bv : xv;
         m = (src == 2 || op == 4) ? imm_data : (mv ^ ea);
         mm = (op == 2) ? ~m : m;
         c = p[7];
         hc = p[6];
         sk = 0;
         r = a + mm + c;
         case (op)
            0: a = (a + m) & 255;
            1, 2:
            begin
               hc = ((a & 15) + (mm & 15) + c) >> 4;
               a = r & 255;
               c = r >> 8;
            end
            3: a = a & m;
            4: sk = (a & m) == 0;
            5: a = a | m;
            default: a = a ^ m;
         endcase
         // look before the first wait: a held request may already have seen done
         k = 0;
         #1;
         while (done !== 1'b1 && k < 8)
         begin
            @(posedge clock);
            #1 k++;
         end
         if (done !== 1'b1)
         begin
            errors++;
            test_done;
         end
         chk(acc_out, a[7:0]);
         chk(stat_word, {c[0], hc[0], p[5:0]});
         chk(ptr_b, bv);
         chk(ptr_x, xv);
         chk(sp, spv);
         chk({7'h00, skip_next}, {7'h00, sk[0]});
      end
      test_done;
   end
endmodule
